// File: asf_pkg.sv
package asf_pkg;

  // ==========================================================
  // interface phase coding
  localparam logic [1:0] DOM_FINAL = 2'h0;
  localparam logic [1:0] DOM_ASSOC = 2'h1;
  localparam logic [1:0] DOM_CRYPT = 2'h2;
  localparam logic MODE_DEC = 1'h1;

  // ==========================================================
  // counters
  localparam int ITER_W = 9;
  localparam int LOAD_BLOCKS = 9;
  localparam int KEY_BLOCKS = 2;
  localparam int FINAL_ITERS = 2;
  localparam int TAG_BLOCKS = 9;
  localparam int ROUND_W = 7;
  localparam int PERM_ROUNDS = 111;
  localparam logic [6:0] ROUND_LAST = 7'(PERM_ROUNDS - 1);
  localparam logic [6:0] ROUND_RST = 7'h00;
  localparam logic [8:0] ITER_RST = 9'h000;
  localparam logic [8:0] ITER_FIRST = 9'h001;

  // ==========================================================
  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] STATE_OFS = 4'h4;
  localparam logic [3:0] COUNT_OFS = 4'h8;
  localparam int CTRL_RESTART_BIT = 0;
  localparam int COUNT_ROUND_POS = 16;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;

  // ==========================================================
  // controller states, one-hot
  typedef enum logic [14:0] {
    LOAD_IDLE_STATE    = 15'h0001,
    LOAD_STATE         = 15'h0002,
    LOAD_PERM_STATE    = 15'h0004,
    INIT_IDLE_STATE    = 15'h0008,
    INIT_ABSORB_STATE  = 15'h0010,
    INIT_PERM_STATE    = 15'h0020,
    DATA_IDLE_STATE    = 15'h0040,
    ASSOC_ABSORB_STATE = 15'h0080,
    ENC_ABSORB_STATE   = 15'h0100,
    DEC_REPLACE_STATE  = 15'h0200,
    DATA_PERM_STATE    = 15'h0400,
    FINAL_ABSORB_STATE = 15'h0800,
    FINAL_PERM_STATE   = 15'h1000,
    FINAL_IDLE_STATE   = 15'h2000,
    TAG_STATE          = 15'h4000
  } asf_state_t;

endpackage

// File: asf_counters.sv
`timescale 1ns/1ps

// ==========================================================
// shared one-hot iteration counter and permutation round counter
module asf_counters (
  input wire logic clk,
  input wire logic rst,
  input wire logic iter_clear,
  input wire logic iter_adv,
  input wire logic round_run,
  output logic [asf_pkg::ITER_W-1:0] iter_q,
  output logic [asf_pkg::ROUND_W-1:0] round_q
);

  logic [asf_pkg::ITER_W-1:0] iter_base;
  logic [asf_pkg::ITER_W-1:0] iter_step;
  logic [asf_pkg::ITER_W-1:0] iter_d;
  logic [asf_pkg::ROUND_W-1:0] round_d;

  // one-hot advance: empty counter takes its first bit
  assign iter_base = iter_clear ? asf_pkg::ITER_RST : iter_q;
  assign iter_step = (iter_base == asf_pkg::ITER_RST) ? asf_pkg::ITER_FIRST : (iter_base << 1);
  assign iter_d = iter_adv ? iter_step : iter_base;
  // round 0 is the first permutation cycle
  assign round_d = round_run ? (round_q + 7'h01) : asf_pkg::ROUND_RST;

  always_ff @(posedge clk) begin
    if (rst) begin
      iter_q <= asf_pkg::ITER_RST;
      round_q <= asf_pkg::ROUND_RST;
    end else begin
      iter_q <= iter_d;
      round_q <= round_d;
    end
  end

endmodule

// File: asf_control_fsm.sv
// Operation
// - after reset: load, one permutation, then initialization
// - separator 1 selects associated data and stays there while it holds
// - separator 2 selects encrypt when direction is 0, decrypt when 1
// - separator 0 from the environment starts finalization
// - finalization leads to tag extraction, then back to load idle
// - split and join points are combinational; each absorb or replace state is one cycle
// - idle states wait for input valid before taking a block
// - ready is low in every permutation state
// - nine key/nonce blocks arrive back to back, counted by iteration counter
// - after loading run 111 rounds, then enter init idle
// - init absorbs a block then permutes 111 rounds, twice
// - data idle: 01 goes to associated data, 10 to encrypt or decrypt
// - each data step is followed by shared 111-round permutation, back to idle
// - round counter is 0 after the exchange; at 110 return and raise ready
// - finalization absorbs and permutes twice; its idle entered once between
// - tag extraction sends nine blocks back to back with no permutation
// - controller drives output valid, ready and datapath controls
// - idle states leave on input valid; data idle also picks its target by separator and stays on 11
// - load, init, final and tag share one one-hot iteration counter
// - equal separators share datapath selects; encrypt and decrypt differ
// - phase changes happen after the permutation completes
// - phase is decoded from direction bit plus two-bit separator
// - encrypt: output rate xor input, store the same xor in rate
// - decrypt: output rate xor input, replace rate with input block
// - absorb, encrypt and decrypt hold the shift; only rate updates
// - loading shifts 7-bit tuples in with nonlinear parts and feedback off
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps

module asf_control_fsm (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic I_VALID,
  input wire logic I_MODE,
  input wire logic [1:0] I_DOM_SEP,
  output logic O_READY,
  output logic O_VALID,
  output logic LOAD,
  output logic ABSORB,
  output logic REPLACE,
  output logic SB_OFF,
  output logic IS_TAG,
  output logic LFSR_EN,
  output logic GEN_OUTPUT,
  input wire logic [asf_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST
);

  // ==========================================================
  // decode helpers
  function automatic logic is_idle(input asf_pkg::asf_state_t s);
    is_idle = (s == asf_pkg::LOAD_IDLE_STATE) || (s == asf_pkg::INIT_IDLE_STATE) ||
              (s == asf_pkg::DATA_IDLE_STATE) || (s == asf_pkg::FINAL_IDLE_STATE);
  endfunction

  function automatic logic is_perm(input asf_pkg::asf_state_t s);
    is_perm = (s == asf_pkg::LOAD_PERM_STATE) || (s == asf_pkg::INIT_PERM_STATE) ||
              (s == asf_pkg::DATA_PERM_STATE) || (s == asf_pkg::FINAL_PERM_STATE);
  endfunction

  function automatic logic is_absorb(input asf_pkg::asf_state_t s);
    is_absorb = (s == asf_pkg::INIT_ABSORB_STATE) || (s == asf_pkg::ASSOC_ABSORB_STATE) ||
                (s == asf_pkg::FINAL_ABSORB_STATE) || (s == asf_pkg::ENC_ABSORB_STATE);
  endfunction

  // ==========================================================
  // state and counters
  asf_pkg::asf_state_t state_q;
  asf_pkg::asf_state_t state_d;
  logic [asf_pkg::ITER_W-1:0] iter_q;
  logic [asf_pkg::ROUND_W-1:0] round_q;
  logic iter_clear;
  logic iter_adv;
  logic round_run;
  logic restart_q;

  wire xfer = I_VALID && O_READY;
  wire round_done = (round_q == asf_pkg::ROUND_LAST);
  wire load_last = iter_q[asf_pkg::LOAD_BLOCKS-1];
  wire key_last = iter_q[asf_pkg::KEY_BLOCKS-1];
  wire final_last = iter_q[asf_pkg::FINAL_ITERS-1];
  wire tag_last = iter_q[asf_pkg::TAG_BLOCKS-1];
  wire dom_assoc = (I_DOM_SEP == asf_pkg::DOM_ASSOC);
  wire dom_crypt = (I_DOM_SEP == asf_pkg::DOM_CRYPT);
  wire dom_final = (I_DOM_SEP == asf_pkg::DOM_FINAL);
  wire mode_dec = (I_MODE == asf_pkg::MODE_DEC);

  asf_counters u_counters (
    .clk(CLK),
    .rst(SYS_RST),
    .iter_clear(iter_clear),
    .iter_adv(iter_adv),
    .round_run(round_run),
    .iter_q(iter_q),
    .round_q(round_q)
  );

  // ==========================================================
  // next state
  always_comb begin
    state_d = state_q;
    iter_clear = 1'b0;
    iter_adv = 1'b0;
    unique case (state_q)
      asf_pkg::LOAD_IDLE_STATE: begin
        if (xfer) begin
          state_d = asf_pkg::LOAD_STATE;
          iter_adv = 1'b1;
        end
      end
      asf_pkg::LOAD_STATE: begin
        if (load_last) begin
          state_d = asf_pkg::LOAD_PERM_STATE;
          iter_clear = 1'b1;
        end else if (xfer) begin
          state_d = asf_pkg::LOAD_STATE;
          iter_adv = 1'b1;
        end else begin
          state_d = asf_pkg::LOAD_IDLE_STATE;
        end
      end
      asf_pkg::LOAD_PERM_STATE: begin
        if (round_done) begin
          state_d = asf_pkg::INIT_IDLE_STATE;
        end
      end
      asf_pkg::INIT_IDLE_STATE: begin
        if (xfer) begin
          state_d = asf_pkg::INIT_ABSORB_STATE;
          iter_adv = 1'b1;
        end
      end
      asf_pkg::INIT_ABSORB_STATE: begin
        state_d = asf_pkg::INIT_PERM_STATE;
      end
      asf_pkg::INIT_PERM_STATE: begin
        if (round_done && key_last) begin
          state_d = asf_pkg::DATA_IDLE_STATE;
          iter_clear = 1'b1;
        end else if (round_done) begin
          state_d = asf_pkg::INIT_IDLE_STATE;
        end
      end
      asf_pkg::DATA_IDLE_STATE: begin
        // the separator picks the target and separator 3 stays idle; leaving needs valid
        if (xfer && dom_assoc) begin
          state_d = asf_pkg::ASSOC_ABSORB_STATE;
        end else if (xfer && dom_crypt && mode_dec) begin
          state_d = asf_pkg::DEC_REPLACE_STATE;
        end else if (xfer && dom_crypt) begin
          state_d = asf_pkg::ENC_ABSORB_STATE;
        end else if (xfer && dom_final) begin
          state_d = asf_pkg::FINAL_ABSORB_STATE;
          iter_adv = 1'b1;
        end
      end
      asf_pkg::ASSOC_ABSORB_STATE, asf_pkg::ENC_ABSORB_STATE, asf_pkg::DEC_REPLACE_STATE: begin
        state_d = asf_pkg::DATA_PERM_STATE;
      end
      asf_pkg::DATA_PERM_STATE: begin
        if (round_done) begin
          state_d = asf_pkg::DATA_IDLE_STATE;
        end
      end
      asf_pkg::FINAL_ABSORB_STATE: begin
        state_d = asf_pkg::FINAL_PERM_STATE;
      end
      asf_pkg::FINAL_PERM_STATE: begin
        if (round_done && final_last) begin
          state_d = asf_pkg::TAG_STATE;
          iter_clear = 1'b1;
          iter_adv = 1'b1;
        end else if (round_done) begin
          state_d = asf_pkg::FINAL_IDLE_STATE;
        end
      end
      asf_pkg::FINAL_IDLE_STATE: begin
        if (xfer) begin
          state_d = asf_pkg::FINAL_ABSORB_STATE;
          iter_adv = 1'b1;
        end
      end
      asf_pkg::TAG_STATE: begin
        if (tag_last) begin
          state_d = asf_pkg::LOAD_IDLE_STATE;
          iter_clear = 1'b1;
        end else begin
          iter_adv = 1'b1;
        end
      end
    endcase
    if (restart_q) begin
      state_d = asf_pkg::LOAD_IDLE_STATE;
      iter_clear = 1'b1;
      iter_adv = 1'b0;
    end
  end

  // round counter runs across consecutive permutation cycles
  assign round_run = is_perm(state_q) && is_perm(state_d);

  // ==========================================================
  // registered handshake and datapath controls
  wire load_ready_d = (state_d == asf_pkg::LOAD_STATE) &&
                      !(iter_adv ? iter_q[asf_pkg::LOAD_BLOCKS-2] : load_last);
  wire ready_d = (is_idle(state_d) || load_ready_d) && !is_perm(state_d);
  wire tag_d = (state_d == asf_pkg::TAG_STATE);
  wire enc_d = (state_d == asf_pkg::ENC_ABSORB_STATE);
  wire dec_d = (state_d == asf_pkg::DEC_REPLACE_STATE);
  wire load_d = (state_d == asf_pkg::LOAD_STATE);
  wire absorb_d = is_absorb(state_d);
  wire replace_d = dec_d;
  wire sb_off_d = load_d || tag_d;
  wire lfsr_en_d = !(absorb_d || replace_d);
  wire gen_d = enc_d || dec_d || tag_d;

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      state_q <= asf_pkg::LOAD_IDLE_STATE;
      O_READY <= 1'b1;
      O_VALID <= 1'b0;
      LOAD <= 1'b0;
      ABSORB <= 1'b0;
      REPLACE <= 1'b0;
      SB_OFF <= 1'b0;
      IS_TAG <= 1'b0;
      LFSR_EN <= 1'b1;
      GEN_OUTPUT <= 1'b0;
    end else begin
      state_q <= state_d;
      O_READY <= ready_d;
      O_VALID <= gen_d;
      LOAD <= load_d;
      ABSORB <= absorb_d;
      REPLACE <= replace_d;
      SB_OFF <= sb_off_d;
      IS_TAG <= tag_d;
      LFSR_EN <= lfsr_en_d;
      GEN_OUTPUT <= gen_d;
    end
  end

  // ==========================================================
  // avalon-mm slave: one wait cycle, then answer
  wire bus_req = AVS_READ || AVS_WRITE;
  wire bus_done = bus_req && !AVS_WAITREQUEST;
  wire sel_ctrl = (AVS_ADDRESS == asf_pkg::CTRL_OFS);
  wire sel_state = (AVS_ADDRESS == asf_pkg::STATE_OFS);
  wire sel_count = (AVS_ADDRESS == asf_pkg::COUNT_OFS);
  wire restart_d = bus_done && AVS_WRITE && sel_ctrl && AVS_BYTEENABLE[0] &&
                   AVS_WRITEDATA[asf_pkg::CTRL_RESTART_BIT];
  wire [31:0] state_word = {17'h00000, state_q};
  wire [31:0] count_word = {9'h000, round_q, 7'h00, iter_q};
  wire [31:0] rdata_d = sel_state ? state_word : (sel_count ? count_word : 32'h0000_0000);

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= asf_pkg::RDATA_RST;
      restart_q <= 1'b0;
    end else begin
      AVS_WAITREQUEST <= !(bus_req && AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST) begin
        AVS_READDATA <= rdata_d;
      end
      restart_q <= restart_d;
    end
  end

endmodule

// File: asf_fsm_checker.sv
`timescale 1ns/1ps

// ==========================================================
// port checks of the controller
module asf_fsm_checker (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic I_VALID,
  input wire logic I_MODE,
  input wire logic [1:0] I_DOM_SEP,
  input wire logic O_READY,
  input wire logic O_VALID,
  input wire logic LOAD,
  input wire logic ABSORB,
  input wire logic REPLACE,
  input wire logic SB_OFF,
  input wire logic IS_TAG,
  input wire logic LFSR_EN,
  input wire logic GEN_OUTPUT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic [7:0] low_q;
  logic [7:0] low_d;
  // cycles spent with ready low
  assign low_d = O_READY ? 8'h00 : low_q + 8'h01;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      low_q <= 8'h00;
    end else begin
      low_q <= low_d;
    end
  end

  // ==========================================================
  // assertions
  load_ctrl_a: assert property (LOAD |-> SB_OFF && !ABSORB && $past(I_VALID && O_READY))
    else $error("load strobe without a taken block");
  replace_src_a: assert property (REPLACE |-> $past(I_VALID && O_READY && I_MODE && I_DOM_SEP == 2'h2))
    else $error("replace without a decrypt block");
  enc_src_a: assert property (ABSORB && O_VALID |-> $past(I_VALID && O_READY && !I_MODE && I_DOM_SEP == 2'h2))
    else $error("encrypt without an encrypt block");
  perm_len_a: assert property ($rose(O_READY) |-> low_q == ($past(IS_TAG) ? 8'h79 : 8'h70))
    else $error("busy period of wrong length");
  tag_run_a: assert property ($rose(IS_TAG) |=> IS_TAG [*8] ##1 !IS_TAG)
    else $error("tag run is not nine cycles");
  tag_out_a: assert property (IS_TAG |-> O_VALID && GEN_OUTPUT && SB_OFF && LFSR_EN && !O_READY)
    else $error("tag cycle controls wrong");
  tag_end_a: assert property ($fell(IS_TAG) |-> O_READY && !LOAD)
    else $error("no return to load idle after tag");
  idle_hold_a: assert property (O_READY && !I_VALID |=> O_READY && !(ABSORB || REPLACE || LOAD))
    else $error("idle left without valid");
  step_hold_a: assert property ((ABSORB || REPLACE) |-> !LFSR_EN && !SB_OFF && !O_READY)
    else $error("shift enabled during absorb or replace");
  gen_valid_a: assert property (GEN_OUTPUT == O_VALID)
    else $error("output strobe and valid disagree");
  cover property (REPLACE);
  cover property (ABSORB && O_VALID);
  cover property ($rose(IS_TAG));
  cover property ($fell(O_READY) && LOAD);
endmodule

bind asf_control_fsm asf_fsm_checker u_asf_fsm_checker (.CLK, .SYS_RST, .I_VALID, .I_MODE, .I_DOM_SEP,
  .O_READY, .O_VALID, .LOAD, .ABSORB, .REPLACE, .SB_OFF, .IS_TAG, .LFSR_EN, .GEN_OUTPUT);

// File: asf_host_model.sv
`timescale 1ns/1ps

// ==========================================================
// host side of the block link
module asf_host_model (
  input wire logic clk,
  input wire logic rdy,
  output logic valid,
  output logic mode,
  output logic [1:0] dom
);
  initial begin
    valid = 1'b0;
    mode = 1'b0;
    dom = 2'h0;
  end

  // n blocks back to back after gap idle cycles
  task automatic xfer(input logic m, input logic [1:0] d, input int gap, input int n);
    int got;
    got = 0;
    repeat (gap + 1) @(posedge clk);
    valid <= 1'b1;
    mode <= m;
    dom <= d;
    while (got < n) begin
      @(posedge clk);
      if (rdy === 1'b1) got++;
    end
    valid <= 1'b0;
    mode <= ~m;
    dom <= ~d;
  endtask
endmodule

// File: asf_control_fsm_tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module asf_control_fsm_tb_top;
  logic CLK;
  logic SYS_RST;
  logic I_VALID, I_MODE;
  logic [1:0] I_DOM_SEP;
  logic O_READY, O_VALID, LOAD, ABSORB, REPLACE, SB_OFF, IS_TAG, LFSR_EN, GEN_OUTPUT;
  logic [3:0] AVS_ADDRESS, AVS_BYTEENABLE;
  logic AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA;
  int err_count = 0;
  int checks = 0;
  int cyc = 0;

  asf_control_fsm u_asf_control_fsm (.CLK, .SYS_RST, .I_VALID, .I_MODE, .I_DOM_SEP, .O_READY, .O_VALID, .LOAD,
    .ABSORB, .REPLACE, .SB_OFF, .IS_TAG, .LFSR_EN, .GEN_OUTPUT, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST);
  asf_host_model u_asf_host_model (.clk(CLK), .rdy(O_READY), .valid(I_VALID), .mode(I_MODE), .dom(I_DOM_SEP));

  // ==========================================================
  // clock and timeout
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      end_sim();
    end
  end

  // ==========================================================
  // helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_READ <= ~wr;
    AVS_WRITE <= wr;
    do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    avs(1'b0, a, 32'h0000_0000, d);
    `CHK(d, e)
  endtask
  // send blocks, check controls of the next cycle, then busy length and tag count
  task automatic step(input logic m, input logic [1:0] d, input int gap, input int n,
    input logic [7:0] ctl, input int wait_n, input int tags);
    int k;
    int t;
    k = 0;
    t = 0;
    u_asf_host_model.xfer(m, d, gap, n);
    @(negedge CLK);
    `CHK(({O_READY, LOAD, SB_OFF, IS_TAG, ABSORB, REPLACE, O_VALID, LFSR_EN}), ctl)
    do begin
      @(posedge CLK);
      k++;
      if (IS_TAG === 1'b1) t++;
    end while (O_READY !== 1'b1 && k < 200);
    `CHK(k, wait_n)
    `CHK(t, tags)
  endtask

  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::LOAD_IDLE_STATE));
    rchk(asf_pkg::COUNT_OFS, 32'h0000_0000);
    avs(1'b1, 4'hC, 32'hFFFF_FFFF, d);
    rchk(4'hC, 32'h0000_0000);
    rchk(asf_pkg::CTRL_OFS, 32'h0000_0000);
    $display("t_regs done");
  endtask
  task automatic t_restart();
    logic [31:0] d;
    u_asf_host_model.xfer(1'b0, 2'h0, 0, 3);
    avs(1'b1, asf_pkg::CTRL_OFS, 32'h0000_0001, d);
    repeat (2) @(posedge CLK);
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::LOAD_IDLE_STATE));
    rchk(asf_pkg::COUNT_OFS, 32'h0000_0000);
    $display("t_restart done");
  endtask
  task automatic t_load();
    step(1'b0, 2'h0, 0, 9, 8'h61, 113, 0);
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::INIT_IDLE_STATE));
    step(1'b1, 2'h0, 0, 1, 8'h08, 113, 0);
    step(1'b0, 2'h0, 2, 1, 8'h08, 113, 0);
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::DATA_IDLE_STATE));
    $display("t_load done");
  endtask
  task automatic t_data();
    step(1'b1, 2'h1, 5, 1, 8'h08, 113, 0);
    step(1'b0, 2'h1, 0, 1, 8'h08, 113, 0);
    step(1'b0, 2'h2, 0, 1, 8'h0A, 113, 0);
    step(1'b1, 2'h2, 0, 1, 8'h06, 113, 0);
    u_asf_host_model.xfer(1'b0, 2'h3, 0, 1);
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::DATA_IDLE_STATE));
    $display("t_data done");
  endtask
  task automatic t_final();
    step(1'b1, 2'h0, 0, 1, 8'h08, 113, 0);
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::FINAL_IDLE_STATE));
    step(1'b0, 2'h2, 3, 1, 8'h08, 122, 9);
    rchk(asf_pkg::STATE_OFS, 32'(asf_pkg::LOAD_IDLE_STATE));
    $display("t_final done");
  endtask

  initial begin
    SYS_RST = 1'b1;
    AVS_ADDRESS = 4'h0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0000_0000;
    AVS_BYTEENABLE = 4'hF;
    repeat (2) @(posedge CLK);
    SYS_RST <= 1'b0;
    t_regs();
    t_restart();
    t_load();
    t_data();
    t_final();
    end_sim();
  end
endmodule
